// [design/multimode_timer_16bit.sv]
// Multimode 16-bit timer with APB register access
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "timer_params.svh"
module multimode_timer_16bit (
	input wire logic pclk, // System clock, 40 MHz
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic timer_in, // Timer input pin
	output logic timer_out, // Timer output pin level
	output logic timer_out_oe, // Timer output drive enable
	output logic timer_irq // Timer interrupt pulse
);
	timer_pkg::timer_config_s cfg;
	timer_pkg::timer_config_s next_cfg;
	timer_pkg::irq_source_e irq_sel;
	timer_pkg::irq_source_e next_irq_sel;
	logic [15:0] count;
	logic [15:0] next_count;
	logic [15:0] reload;
	logic [15:0] next_reload;
	logic [15:0] capture;
	logic [15:0] next_capture;
	logic cap_flag;
	logic next_cap_flag;
	logic out_level;
	logic next_out_level;
	logic pulse_pending;
	logic next_pulse_pending;
	logic armed;
	logic next_armed;
	logic irq;
	logic next_irq;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic en_d;
	logic tick;
	logic in_level;
	logic in_rise;
	logic in_fall;
	logic wr;
	logic rd;
	logic mapped;
	logic active;
	logic edge_hit;
	logic deassert;
	logic at_reload;
	timer_pkg::timer_event_s ev;

	function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
		addr_is = (a == off);
	endfunction

	timer_input_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin(timer_in),
		.level(in_level),
		.rise(in_rise),
		.fall(in_fall)
	);

	// Divider restarts on the enabling edge so the first period is full length
	timer_prescaler #(.WIDTH(7)) u_pres (
		.pclk(pclk),
		.presetn(presetn),
		.restart(cfg.enable && !en_d),
		.prescale(cfg.prescale),
		.tick(tick)
	);

	assign wr = psel && penable && pwrite;
	// Read word is latched in the setup cycle and stands through the access phase
	assign rd = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign mapped = addr_is(paddr, `TMR_OFF_CTL0) || addr_is(paddr, `TMR_OFF_CTL1)
		|| addr_is(paddr, `TMR_OFF_COUNT) || addr_is(paddr, `TMR_OFF_RELOAD)
		|| addr_is(paddr, `TMR_OFF_CAPTURE) || addr_is(paddr, `TMR_OFF_STATUS);
	assign pslverr = psel && penable && !mapped;

	always_comb
	begin
		next_rdata = rdata;
		if (rd)
		begin
			next_rdata = 32'h0000_0000;
			if (addr_is(paddr, `TMR_OFF_CTL0))
				next_rdata = {23'h00_0000, cfg};
			else if (addr_is(paddr, `TMR_OFF_CTL1))
				next_rdata = {29'h0000_0000, cap_flag, irq_sel};
			else if (addr_is(paddr, `TMR_OFF_COUNT))
				next_rdata = {16'h0000, count};
			else if (addr_is(paddr, `TMR_OFF_RELOAD))
				next_rdata = {16'h0000, reload};
			else if (addr_is(paddr, `TMR_OFF_CAPTURE))
				next_rdata = {16'h0000, capture};
			else if (addr_is(paddr, `TMR_OFF_STATUS))
				next_rdata = {30'h0000_0000, armed, in_level};
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rdata <= 32'h0000_0000;
		else
			rdata <= next_rdata;
	end

	// Gated uses the pin level and capture the pin edge relative to polarity
	assign active = (in_level == cfg.input_output_polarity_bit);
	assign edge_hit = cfg.input_output_polarity_bit ? in_rise : in_fall;
	assign deassert = cfg.input_output_polarity_bit ? in_fall : in_rise;
	assign at_reload = (count == reload);

	always_comb
	begin
		next_cfg = cfg;
		next_irq_sel = irq_sel;
		next_reload = reload;
		next_count = count;
		next_capture = capture;
		next_cap_flag = cap_flag;
		next_out_level = out_level;
		next_pulse_pending = 1'b0;
		next_armed = armed;
		next_irq = 1'b0;
		ev = '0;
		if (cfg.enable)
		begin
			case (cfg.mode)
				timer_pkg::MODE_ONESHOT:
				begin
					if (tick)
					begin
						if (at_reload)
						begin
							ev.reload = 1'b1;
							next_cfg.enable = 1'b0;
							next_count = `TMR_COUNT_RESTART;
							next_pulse_pending = cfg.output_enable;
						end
						else
							next_count = count + 16'h0001;
					end
				end
				timer_pkg::MODE_CONTINUOUS, timer_pkg::MODE_COMPARE:
				begin
					if (tick)
					begin
						if (at_reload)
						begin
							ev.reload = 1'b1;
							if (cfg.mode == timer_pkg::MODE_COMPARE)
								next_cfg.enable = 1'b0;
							else
								next_count = `TMR_COUNT_RESTART;
						end
						else
							next_count = count + 16'h0001;
					end
				end
				timer_pkg::MODE_GATED:
				begin
					ev.deassert = deassert;
					if (tick && active)
					begin
						if (at_reload)
						begin
							ev.reload = 1'b1;
							next_count = `TMR_COUNT_RESTART;
						end
						else
							next_count = count + 16'h0001;
					end
				end
				timer_pkg::MODE_CAPTURE:
				begin
					if (!armed)
						next_armed = edge_hit;
					else if (edge_hit)
					begin
						ev.capture = 1'b1;
						next_capture = count;
						next_count = `TMR_COUNT_RESTART;
						next_cap_flag = 1'b1;
					end
					else if (tick)
					begin
						if (at_reload)
						begin
							ev.reload = 1'b1;
							next_count = `TMR_COUNT_RESTART;
							next_cap_flag = 1'b0;
						end
						else
							next_count = count + 16'h0001;
					end
				end
				default:
				begin
					next_count = count;
				end
			endcase
			// Toggle on reload; one-shot pulse is restored next cycle instead
			if (ev.reload && cfg.output_enable)
				next_out_level = !out_level;
			case (irq_sel)
				timer_pkg::IRQ_BOTH:
					next_irq = ev.reload || ev.capture || ev.deassert;
				timer_pkg::IRQ_FIRST_ONLY:
					next_irq = ev.capture || ev.deassert;
				timer_pkg::IRQ_RELOAD_ONLY:
					next_irq = ev.reload;
				default:
					next_irq = ev.reload;
			endcase
		end
		else
			next_armed = 1'b0;
		if (pulse_pending)
			next_out_level = !out_level;
		if (wr)
		begin
			if (addr_is(paddr, `TMR_OFF_CTL0))
			begin
				next_cfg = timer_pkg::timer_config_s'(pwdata[8:0]);
				if (!cfg.enable)
					next_out_level = pwdata[`TMR_CTL0_POL];
			end
			else if (addr_is(paddr, `TMR_OFF_CTL1))
				next_irq_sel = timer_pkg::irq_source_e'(pwdata[1:0]);
			else if (addr_is(paddr, `TMR_OFF_COUNT))
				next_count = pwdata[15:0];
			else if (addr_is(paddr, `TMR_OFF_RELOAD))
				next_reload = pwdata[15:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg <= '0;
			irq_sel <= timer_pkg::IRQ_BOTH;
			count <= `TMR_COUNT_RESET;
			reload <= `TMR_RELOAD_RESET;
			capture <= 16'h0000;
			cap_flag <= 1'b0;
			out_level <= 1'b0;
			pulse_pending <= 1'b0;
			armed <= 1'b0;
			irq <= 1'b0;
			en_d <= 1'b0;
		end
		else
		begin
			cfg <= next_cfg;
			irq_sel <= next_irq_sel;
			count <= next_count;
			reload <= next_reload;
			capture <= next_capture;
			cap_flag <= next_cap_flag;
			out_level <= next_out_level;
			pulse_pending <= next_pulse_pending;
			armed <= next_armed;
			irq <= next_irq;
			en_d <= cfg.enable;
		end
	end

	assign timer_out = out_level;
	assign timer_out_oe = cfg.output_enable;
	assign timer_irq = irq;
	assign prdata = rdata;

	one_shot_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		(pulse_pending && !wr) |=> (timer_out != $past(timer_out)))
		else $error("one-shot pulse not restored");
	idle_no_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!cfg.enable && !wr) |=> (!timer_irq && count == $past(count)))
		else $error("disabled timer changed");
	reload_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg.enable && cfg.mode == timer_pkg::MODE_CONTINUOUS && tick && at_reload && !wr)
		|=> count == 16'h0001)
		else $error("continuous reload value wrong");
	cont_toggle_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg.enable && cfg.mode == timer_pkg::MODE_CONTINUOUS && cfg.output_enable
		&& tick && at_reload && !wr && !pulse_pending) |=> $changed(timer_out))
		else $error("output did not toggle");
	gated_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg.enable && cfg.mode == timer_pkg::MODE_GATED && !active && !wr)
		|=> $stable(count))
		else $error("gated counted while inactive");
	gated_deassert_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg.enable && cfg.mode == timer_pkg::MODE_GATED && deassert
		&& irq_sel != timer_pkg::IRQ_RELOAD_ONLY) |=> timer_irq)
		else $error("no deassert interrupt");
	capture_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg.enable && cfg.mode == timer_pkg::MODE_CAPTURE && armed && edge_hit && !wr)
		|=> (cap_flag && capture == $past(count) && count == 16'h0001))
		else $error("capture event mishandled");
	capture_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg.enable && cfg.mode == timer_pkg::MODE_CAPTURE && !armed && !wr)
		|=> $stable(count))
		else $error("counted before first edge");
	oneshot_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg.enable && cfg.mode == timer_pkg::MODE_ONESHOT && tick && at_reload && !wr)
		|=> (!cfg.enable && count == `TMR_COUNT_RESTART))
		else $error("one-shot did not stop at reload");
	oneshot_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg.enable && cfg.mode == timer_pkg::MODE_ONESHOT && !tick && !wr)
		|=> $stable(count))
		else $error("one-shot counted without prescaler tick");
	cont_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg.enable && cfg.mode == timer_pkg::MODE_CONTINUOUS && tick && at_reload
		&& irq_sel != timer_pkg::IRQ_FIRST_ONLY) |=> timer_irq)
		else $error("no reload interrupt");
	compare_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg.enable && cfg.mode == timer_pkg::MODE_COMPARE && tick && at_reload && !wr)
		|=> (!cfg.enable && count == $past(count)))
		else $error("compare match did not stop the timer");
	capture_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg.enable && cfg.mode == timer_pkg::MODE_CAPTURE && armed && edge_hit
		&& (irq_sel == timer_pkg::IRQ_BOTH || irq_sel == timer_pkg::IRQ_FIRST_ONLY)) |=> timer_irq)
		else $error("no capture interrupt");
	irq_select_a: assert property (@(posedge pclk) disable iff (!presetn)
		(irq_sel == timer_pkg::IRQ_RELOAD_ONLY && !ev.reload) |=> !timer_irq)
		else $error("interrupt from a filtered source");
	disabled_output_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!cfg.enable && !wr && !pulse_pending) |=> $stable(timer_out))
		else $error("output moved while disabled");
endmodule
`default_nettype wire

// [pkg/timer_params.svh]
// Offsets, field positions, reset values and timing counts of the timer
// What this block does
// - One-shot reload inverts the output pin for exactly one clock.
// - One-shot counting advances on the prescaled clock.
// - Continuous mode counts to reload, interrupts, reloads 0001H, continues.
// - Continuous mode toggles and holds the output level on each reload.
// - Compare mode counts on the prescaled clock toward the compare value.
// - Gated mode counts only while the input is at its active level.
// - Gated mode interrupts on input deassertion and on reload.
// - Gated mode reload loads 0001H and continues while input stays active.
// - Gated mode toggles the output on each reload.
// - Gated mode start count applies only to the first pass.
// - Gated interrupt source select defaults to both events, restrictable.
// - Capture mode idles until first qualifying edge, polarity picks the edge.
// - Later edges capture count, interrupt, load 0001H and continue.
// - A capture interrupt sets the capture event flag.
// - Compare match without edge interrupts, loads 0001H, clears the flag.
// - Capture interrupt source select defaults to both, restrictable.
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH
`define TMR_OFF_CTL0 12'h000
`define TMR_OFF_CTL1 12'h004
`define TMR_OFF_COUNT 12'h008
`define TMR_OFF_RELOAD 12'h00C
`define TMR_OFF_CAPTURE 12'h010
`define TMR_OFF_STATUS 12'h014
`define TMR_CTL0_EN 0
`define TMR_CTL0_MODE_LSB 1
`define TMR_CTL0_PRES_LSB 4
`define TMR_CTL0_POL 7
`define TMR_CTL0_OUTEN 8
`define TMR_CTL1_CFG_LSB 0
`define TMR_CTL1_CAPFLAG 2
`define TMR_COUNT_RESTART 16'h0001
`define TMR_RELOAD_RESET 16'hFFFF
`define TMR_COUNT_RESET 16'h0000
`endif

// [pkg/timer_pkg.sv]
// Types shared by the timer files
`default_nettype none
package timer_pkg;
	typedef enum logic [2:0] {
		MODE_ONESHOT = 3'h0,
		MODE_CONTINUOUS = 3'h1,
		MODE_COMPARE = 3'h2,
		MODE_GATED = 3'h3,
		MODE_CAPTURE = 3'h4
	} timer_mode_e;
	typedef enum logic [1:0] {
		IRQ_BOTH = 2'h0,
		IRQ_FIRST_ONLY = 2'h1,
		IRQ_RELOAD_ONLY = 2'h2
	} irq_source_e;
	typedef struct packed {
		logic output_enable;
		logic input_output_polarity_bit;
		logic [2:0] prescale;
		timer_mode_e mode;
		logic enable;
	} timer_config_s;
	typedef struct packed {
		logic reload;
		logic capture;
		logic deassert;
	} timer_event_s;
endpackage
`default_nettype wire

// [design/timer_prescaler.sv]
// Prescaler giving a one-cycle count enable every 2^prescale clocks
`timescale 1ns/1ps
`default_nettype none
module timer_prescaler #(
	parameter int WIDTH = 7
) (
	input wire logic pclk, // System clock
	input wire logic presetn, // Async reset, active low
	input wire logic restart, // Clear the divider
	input wire logic [2:0] prescale, // Log2 divide factor
	output logic tick // Count enable pulse
);
	logic [WIDTH-1:0] div;
	logic [WIDTH-1:0] next_div;
	logic [WIDTH-1:0] limit;
	always_comb
	begin
		limit = WIDTH'((1 << prescale) - 1);
		tick = (div == limit) && !restart;
		next_div = (restart || tick) ? '0 : div + WIDTH'(1);
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div <= '0;
		else
			div <= next_div;
	end
endmodule
`default_nettype wire

// [design/timer_input_sync.sv]
// Two-stage synchroniser and edge detect for the timer input pin
`timescale 1ns/1ps
`default_nettype none
module timer_input_sync (
	input wire logic pclk, // System clock
	input wire logic presetn, // Async reset, active low
	input wire logic pin, // Raw timer input pin
	output logic level, // Synchronised level
	output logic rise, // Rising edge pulse
	output logic fall // Falling edge pulse
);
	logic meta;
	logic sync;
	logic prev;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta <= 1'b0;
			sync <= 1'b0;
			prev <= 1'b0;
		end
		else
		begin
			meta <= pin;
			sync <= meta;
			prev <= sync;
		end
	end
	always_comb
	begin
		level = sync;
		rise = sync && !prev;
		fall = !sync && prev;
	end
endmodule
`default_nettype wire

// [verification/timer_pin_model.sv]
// External source that drives the timer input pin
`timescale 1ns/1ps
`default_nettype none
module timer_pin_model (
	input wire logic pclk, // System clock
	input wire logic gate, // Requested pin level
	output logic timer_in // Pin as seen by the timer
);
	// Registered so that the pin follows gate one clock later and changes only on a rising clock edge
	always_ff @(posedge pclk)
	begin
		timer_in <= gate;
	end
endmodule
`default_nettype wire

// [verification/multimode_timer_16bit_tb_top.sv]
// Self-checking bench for the multimode timer
`timescale 1ns/1ps
`default_nettype none
`include "timer_params.svh"
module multimode_timer_16bit_tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic timer_in;
	logic timer_out;
	logic timer_irq;
	logic timer_out_oe;
	logic gate = 1'b0;
	logic [31:0] rd;
	logic err;
	int num_errors = 0;
	int compares = 0;
	int n;
	always #12.5 pclk = ~pclk;
	multimode_timer_16bit dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_in(timer_in),
		.timer_out(timer_out), .timer_out_oe(timer_out_oe), .timer_irq(timer_irq));
	timer_pin_model pin_u (.pclk(pclk), .gate(gate), .timer_in(timer_in));
	task automatic print_verdict();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle cycle so the next call never reassigns psel in this time step
		@(posedge pclk);
		if (k >= 20)
		begin
			num_errors++;
			print_verdict();
		end
	endtask
	task automatic wait_irq(input int lim);
		n = 0;
		do
		begin
			@(negedge pclk);
			n++;
		end
		while (timer_irq !== 1'b1 && n < lim);
		if (timer_irq !== 1'b1)
		begin
			num_errors++;
			print_verdict();
		end
	endtask
	function automatic logic [31:0] ctl(logic oe, logic pol, logic [2:0] p,
		timer_pkg::timer_mode_e m, logic en);
		return {23'h0, oe, pol, p, m, en};
	endfunction
	// Disable and configure first, enable last
	task automatic setup(timer_pkg::timer_mode_e m, logic pol, logic oe, logic [2:0] p,
		logic [15:0] start, logic [15:0] rel, logic [1:0] src);
		apb(1'b1, `TMR_OFF_CTL0, ctl(oe, pol, p, m, 1'b0));
		apb(1'b1, `TMR_OFF_COUNT, {16'h0000, start});
		apb(1'b1, `TMR_OFF_RELOAD, {16'h0000, rel});
		apb(1'b1, `TMR_OFF_CTL1, {30'h0, src});
		apb(1'b1, `TMR_OFF_CTL0, ctl(oe, pol, p, m, 1'b1));
		@(posedge pclk);
	endtask
	task automatic s_bus();
		apb(1'b0, `TMR_OFF_RELOAD, 32'h0000_0000);
		check("reload reset", 32'h0000_FFFF, rd);
		apb(1'b0, 12'h020, 32'h0000_0000);
		check("unmapped error", 32'h0000_0001, {31'h0, err});
	endtask
	// Prescale 2 and reload 10 gives 20 clocks between reloads
	task automatic s_continuous();
		logic o1;
		setup(timer_pkg::MODE_CONTINUOUS, 1'b0, 1'b1, 3'h1, 16'h0001, 16'h000A, 2'h0);
		check("output drive on", 32'h1, {31'h0, timer_out_oe});
		wait_irq(100);
		repeat (2) @(negedge pclk);
		o1 = timer_out;
		wait_irq(100);
		check("reload period", 32'd18, n);
		repeat (2) @(negedge pclk);
		check("output toggle", {31'h0, ~o1}, {31'h0, timer_out});
	endtask
	task automatic s_disabled();
		logic [31:0] c1;
		logic o;
		apb(1'b1, `TMR_OFF_CTL0, ctl(1'b1, 1'b0, 3'h0, timer_pkg::MODE_CONTINUOUS, 1'b0));
		apb(1'b0, `TMR_OFF_COUNT, 32'h0000_0000);
		c1 = rd;
		o = timer_out;
		n = 0;
		repeat (40)
		begin
			@(negedge pclk);
			if (timer_irq !== 1'b0 || timer_out !== o)
				n++;
		end
		check("irq or toggle while off", 32'd0, n);
		apb(1'b0, `TMR_OFF_COUNT, 32'h0000_0000);
		check("count held", c1, rd);
	endtask
	task automatic s_gated();
		logic [31:0] c1;
		gate <= 1'b0;
		setup(timer_pkg::MODE_GATED, 1'b1, 1'b0, 3'h0, 16'h0001, 16'hFFFF, 2'h0);
		check("output drive off", 32'h0, {31'h0, timer_out_oe});
		apb(1'b0, `TMR_OFF_COUNT, 32'h0000_0000);
		c1 = rd;
		repeat (20) @(posedge pclk);
		apb(1'b0, `TMR_OFF_COUNT, 32'h0000_0000);
		check("gate closed", c1, rd);
		gate <= 1'b1;
		repeat (30) @(posedge pclk);
		gate <= 1'b0;
		wait_irq(20);
		// Pin level differs from polarity, so the interrupt came from deassertion
		apb(1'b0, `TMR_OFF_STATUS, 32'h0000_0000);
		check("deassert source", 32'h0, rd & 32'h0000_0001);
		repeat (5) @(posedge pclk);
		apb(1'b0, `TMR_OFF_COUNT, 32'h0000_0000);
		check("gate open", 32'd1, {31'h0, rd > c1 + 32'd20});
	endtask
	// Edges 40 clocks apart, sync delay equal on both
	task automatic s_capture();
		setup(timer_pkg::MODE_CAPTURE, 1'b1, 1'b0, 3'h0, 16'h0001, 16'hFFFF, 2'h0);
		repeat (10) @(posedge pclk);
		apb(1'b0, `TMR_OFF_COUNT, 32'h0000_0000);
		check("idle before edge", 32'h0000_0001, rd);
		gate <= 1'b1;
		repeat (30) @(posedge pclk);
		gate <= 1'b0;
		repeat (10) @(posedge pclk);
		gate <= 1'b1;
		wait_irq(20);
		apb(1'b0, `TMR_OFF_CTL1, 32'h0000_0000);
		check("capture flag", 32'h0000_0004, rd & 32'h0000_0004);
		apb(1'b0, `TMR_OFF_CAPTURE, 32'h0000_0000);
		check("capture value", 32'd1, {31'h0, rd inside {[32'd38:32'd44]}});
	endtask
	task automatic s_oneshot();
		setup(timer_pkg::MODE_ONESHOT, 1'b0, 1'b1, 3'h0, 16'h0001, 16'h0008, 2'h0);
		n = 0;
		repeat (40)
		begin
			@(negedge pclk);
			if (timer_out !== 1'b0)
				n++;
		end
		check("one-shot pulse", 32'd1, n);
	endtask
	// Reload-only interrupts; compare match toggles the output and stops the timer
	task automatic s_compare();
		setup(timer_pkg::MODE_COMPARE, 1'b0, 1'b1, 3'h0, 16'h0001, 16'h0005, 2'h2);
		wait_irq(40);
		repeat (2) @(negedge pclk);
		check("compare level", 32'h1, {31'h0, timer_out});
		apb(1'b0, `TMR_OFF_CTL0, 32'h0000_0000);
		check("compare stop", 32'h0, rd & 32'h0000_0001);
	endtask
	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		s_bus();
		s_continuous();
		s_disabled();
		s_gated();
		s_capture();
		s_oneshot();
		s_compare();
		print_verdict();
	end
endmodule
`default_nettype wire
